// *** logic/app_pkg.sv ***
// Package of register map, field layouts and types for the auxiliary pin port
package app_pkg;

  // Register byte offsets
  localparam logic [7:0] APP_OFF_DIR = 8'h00;
  localparam logic [7:0] APP_OFF_TX = 8'h04;
  localparam logic [7:0] APP_OFF_RX = 8'h08;
  localparam logic [7:0] APP_OFF_DRV = 8'h0C;
  localparam logic [7:0] APP_OFF_FUNC = 8'h10;
  localparam logic [7:0] APP_OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] APP_OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] APP_OFF_STATUS = 8'h1C;
  localparam int APP_ADDR_W = 8;

  // Reset values
  localparam logic [7:0] APP_DIR_RST = 8'hFF;
  localparam logic [7:0] APP_TX_RST = 8'h00;
  localparam logic [7:0] APP_DRV_RST = 8'h00;
  localparam logic [1:0] APP_MASK_RST = 2'h3;

  // Pin positions with a special role
  localparam int APP_PIN_MULTIFRAME_BIT_PIN = 4;
  localparam int APP_PIN_CLK = 5;
  localparam int APP_PIN_IRQ_A = 6;
  localparam int APP_PIN_IRQ_B = 7;
  localparam int APP_NUM_STRAP = 3;

  // Width of the function config field in the register word
  localparam int APP_FUNC_W = 7;

  // Operating mode as decoded from the two mode straps plus the intelligent NT bit
  typedef enum logic [2:0] {
    APP_MODE_TE = 3'b000,
    APP_MODE_LTT = 3'b001,
    APP_MODE_LTS = 3'b010,
    APP_MODE_NT = 3'b011,
    APP_MODE_INT_NT = 3'b100
  } app_mode_t;

  // Function configuration register, bit 0 at the bottom
  typedef struct packed {
    logic intelligent_nt;
    logic multiframe_select;
    logic stop_go_select;
    logic trig_type_b;
    logic trig_type_a;
    logic clock_output_source;
    logic pin5_function_select;
  } app_func_cfg_t;

  // Board-side pin bundle driven by the port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pullup_en;
  } app_pins_t;

endpackage : app_pkg

// *** logic/app_aux_pin_port.sv ***
// Auxiliary pin port with AHB-Lite register slave
//
// Overview of operation
// R1: After reset every auxiliary pin is an input until software reconfigures it.
// R2: Strapped mode picks pin functions; pins 0-2 are channel straps in linecard modes.
// R3: Direction bit 1 makes an input; level sampled when receive register is read.
// R4: Direction bit 0 drives the transmit register bit onto the pin promptly.
// R5: Drive type bit 0 gives open drain, 1 gives push-pull.
// R6: Receive register reads the real pin level, also for outputs under contention.
// R7: Pin 5 is ordinary I/O when select is 0, clock output when 1.
// R8: Clock output gives frame sync when source is 0, bit clock when 1.
// R9: Pins 6 and 7 are I/O with interrupt input; both masked after reset.
// R10: Input interrupt pins set own status flags; per-pin mask gates host interrupt.
// R11: Each interrupt pin is edge or level triggered by its own trigger bit.
// R12: Pull-ups on pins 6 and 7 except when push-pull output is selected.
// R13: With stop/go select 1, pin 7 outputs the stop/go bit.
// R14: With multiframe select 1, pin 4 serves multiframe; its I/O settings ignored.
// R15: Multiframe pin outputs M-bit in TE/LT-T, receives it in LT-S/NT/intelligent NT.
// R16: In LT-T/LT-S the three straps decode binary, pin 2 MSB, channel 0-7.
// R17: Board straps only channels 0-2 at the slow data clock rate.
// R18: Decoded channel offsets timeslot selection of transceiver, D/C-I and monitor control.
// R19: Linecard frame holds up to eight channels of B, monitor, D, C/I, handshake.
// R20: Interrupt pins pass a two-flop synchroniser before edge or level detection.
`timescale 1ns/1ns
module app_aux_pin_port
  import app_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [7:0] aux_in,
  input wire logic operating_mode_strap_a,
  input wire logic operating_mode_strap_b,
  input wire logic data_clock,
  input wire logic frame_sync,
  input wire logic stop_go_bit,
  input wire logic multiframe_bit_tx,
  output app_pkg::app_pins_t aux_pins,
  output logic multiframe_bit_rx,
  output logic [2:0] channel_number,
  output logic irq
);
  import app_pkg::*;

  // Software-visible state
  logic [7:0] dir_q;
  logic [7:0] tx_q;
  logic [7:0] drv_q;
  app_func_cfg_t func_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;

  // Bus data phase bookkeeping
  logic wr_pend_q;
  logic [APP_ADDR_W-1:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;

  // Synchronisers for every asynchronous input
  logic [7:0] pin_meta_q, pin_sync_q;
  logic [1:0] strap_meta_q, strap_sync_q;
  logic dclk_meta_q, dclk_sync_q, dclk_prev_q;
  logic fsync_meta_q, fsync_sync_q;
  logic [1:0] irq_prev_q;

  // Derived state and outputs
  logic bit_clock_q;
  app_mode_t mode;
  logic linecard;
  logic [2:0] chan_q;
  logic multiframe_bit_pin_rx_q;
  logic irq_q;
  app_pins_t pins_d, pins_q;
  logic addr_phase;
  logic [31:0] rd_val;
  logic [1:0] irq_event;
  logic [1:0] irq_clr;

  // Two-flop synchronisers; the first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end
    else
    begin
      pin_meta_q <= aux_in;
      pin_sync_q <= pin_meta_q; // [R20]
    end
  end

  // Mode straps are static in use but still sampled safely
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strap_meta_q <= 2'h0;
      strap_sync_q <= 2'h0;
    end
    else
    begin
      strap_meta_q <= {operating_mode_strap_b, operating_mode_strap_a};
      strap_sync_q <= strap_meta_q;
    end
  end

  // Data clock sampled; it must stay well below half the bus clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dclk_meta_q <= 1'b0;
      dclk_sync_q <= 1'b0;
    end
    else
    begin
      dclk_meta_q <= data_clock;
      dclk_sync_q <= dclk_meta_q;
    end
  end

  // Frame sync sampled for the clock output pin
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fsync_meta_q <= 1'b0;
      fsync_sync_q <= 1'b0;
    end
    else
    begin
      fsync_meta_q <= frame_sync;
      fsync_sync_q <= fsync_meta_q;
    end
  end

  // Mode decode; intelligent NT is the NT strap with the software bit set
  always_comb
  begin
    case (strap_sync_q)
      2'h0: mode = APP_MODE_TE;
      2'h1: mode = APP_MODE_LTT;
      2'h2: mode = APP_MODE_LTS;
      2'h3: mode = func_q.intelligent_nt ? APP_MODE_INT_NT : APP_MODE_NT;
      default: mode = APP_MODE_TE;
    endcase
  end

  // Pins 0-2 become channel straps in LT-T, LT-S and NT
  assign linecard = (mode == APP_MODE_LTT) || (mode == APP_MODE_LTS) || (mode == APP_MODE_NT); // [R2]

  // Bit clock is the data clock halved, stepped on each rising data clock edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dclk_prev_q <= 1'b0;
      bit_clock_q <= 1'b0;
    end
    else
    begin
      dclk_prev_q <= dclk_sync_q;
      if (dclk_sync_q && !dclk_prev_q)
        bit_clock_q <= ~bit_clock_q; // [R8]
    end
  end

  // Channel number, pin 2 as MSB; forced to zero outside LT-T/LT-S, NT included
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      chan_q <= 3'h0;
    else if (mode == APP_MODE_LTT || mode == APP_MODE_LTS)
      chan_q <= pin_sync_q[APP_NUM_STRAP-1:0]; // [R16] [R18] [R19]
    else
      chan_q <= 3'h0;
  end

  // Per-pin driver: direction, drive type and alternate functions
  for (genvar i = 0; i < 8; i++)
  begin : g_pin
    logic drive;
    logic push_pull;
    logic value;
    always_comb
    begin
      drive = ~dir_q[i]; // [R3] [R4]
      push_pull = drv_q[i];
      value = tx_q[i];
      if (i < APP_NUM_STRAP && linecard)
        drive = 1'b0; // [R2]
      if (i == APP_PIN_MULTIFRAME_BIT_PIN && func_q.multiframe_select)
      begin
        // GPIO settings are ignored; direction follows the mode
        drive = (mode == APP_MODE_TE) || (mode == APP_MODE_LTT); // [R14] [R15]
        push_pull = 1'b1;
        value = multiframe_bit_tx;
      end
      if (i == APP_PIN_CLK && func_q.pin5_function_select)
      begin
        drive = 1'b1; // [R7]
        push_pull = 1'b1;
        value = func_q.clock_output_source ? bit_clock_q : fsync_sync_q; // [R8]
      end
      if (i == APP_PIN_IRQ_B && func_q.stop_go_select)
      begin
        drive = 1'b1; // [R13]
        push_pull = 1'b1;
        value = stop_go_bit;
      end
      // Open drain only pulls low, so the enable carries the data
      pins_d.oe[i] = drive & (push_pull | ~value); // [R5]
      pins_d.out[i] = push_pull & value;
      if (i == APP_PIN_IRQ_A || i == APP_PIN_IRQ_B)
        pins_d.pullup_en[i] = ~(drive & push_pull); // [R12]
      else
        pins_d.pullup_en[i] = 1'b0;
    end
  end

  // Pins are registered so the board sees no glitches from the mux
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pins_q <= '{out: 8'h00, oe: 8'h00, pullup_en: 8'hC0}; // [R1]
    else
      pins_q <= pins_d;
  end

  // Received M-bit in LT-S, NT and intelligent NT
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      multiframe_bit_pin_rx_q <= 1'b0;
    else if (func_q.multiframe_select && mode != APP_MODE_TE && mode != APP_MODE_LTT)
      multiframe_bit_pin_rx_q <= pin_sync_q[APP_PIN_MULTIFRAME_BIT_PIN]; // [R15]
  end

  // Interrupt detection: level means low, edge means falling; only while input
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_prev_q <= 2'h0; // Matches the cleared synchroniser, so release gives no false edge
    else
      irq_prev_q <= pin_sync_q[APP_PIN_IRQ_B:APP_PIN_IRQ_A];
  end

  always_comb
  begin
    irq_event[0] = dir_q[APP_PIN_IRQ_A] &
      (func_q.trig_type_a ? ~pin_sync_q[APP_PIN_IRQ_A] :
       (irq_prev_q[0] & ~pin_sync_q[APP_PIN_IRQ_A])); // [R10] [R11]
    irq_event[1] = dir_q[APP_PIN_IRQ_B] & ~func_q.stop_go_select &
      (func_q.trig_type_b ? ~pin_sync_q[APP_PIN_IRQ_B] :
       (irq_prev_q[1] & ~pin_sync_q[APP_PIN_IRQ_B])); // [R10] [R11]
  end

  // Address phase taken only when the bus is ready and the transfer is real
  assign addr_phase = hsel && htrans[1] && hready;
  assign irq_clr = (wr_pend_q && wr_addr_q == APP_OFF_IRQ_STAT) ? hwdata[1:0] : 2'h0;

  // Sticky status; a new event in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_q <= 2'h0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_event; // [R10]
  end

  // Host interrupt, mask bit 1 blocks the pin
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_stat_q & ~irq_mask_q); // [R9] [R10]
  end

  // Write capture: address phase latched, data applied in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end
    else
    begin
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= haddr[APP_ADDR_W-1:0];
    end
  end

  // Direction register; every pin an input after reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dir_q <= APP_DIR_RST; // [R1]
    else if (wr_pend_q && wr_addr_q == APP_OFF_DIR)
      dir_q <= hwdata[7:0];
  end

  // Transmit register; the pins follow one edge later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_q <= APP_TX_RST;
    else if (wr_pend_q && wr_addr_q == APP_OFF_TX)
      tx_q <= hwdata[7:0]; // [R4]
  end

  // Drive type register; open drain after reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      drv_q <= APP_DRV_RST;
    else if (wr_pend_q && wr_addr_q == APP_OFF_DRV)
      drv_q <= hwdata[7:0]; // [R5]
  end

  // Function config; plain I/O and frame sync source after reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      func_q <= '0; // [R7] [R8]
    else if (wr_pend_q && wr_addr_q == APP_OFF_FUNC)
      func_q <= hwdata[APP_FUNC_W-1:0];
  end

  // Interrupt mask; both pins masked after reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_mask_q <= APP_MASK_RST; // [R9]
    else if (wr_pend_q && wr_addr_q == APP_OFF_IRQ_MASK)
      irq_mask_q <= hwdata[1:0];
  end

  // Read mux; receive value is the pin level at the moment of the read
  always_comb
  begin
    case (haddr[APP_ADDR_W-1:0])
      APP_OFF_DIR: rd_val = {24'h000000, dir_q};
      APP_OFF_TX: rd_val = {24'h000000, tx_q};
      APP_OFF_RX: rd_val = {24'h000000, pin_sync_q}; // [R3] [R6]
      APP_OFF_DRV: rd_val = {24'h000000, drv_q};
      APP_OFF_FUNC: rd_val = {25'h0000000, func_q};
      APP_OFF_IRQ_STAT: rd_val = {30'h00000000, irq_stat_q};
      APP_OFF_IRQ_MASK: rd_val = {30'h00000000, irq_mask_q};
      APP_OFF_STATUS: rd_val = {26'h0000000, chan_q, mode};
      default: rd_val = 32'h00000000;
    endcase
  end

  // Read data registered at the address phase so the data phase needs no wait
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      if (addr_phase && !hwrite)
        hrdata_q <= rd_val;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign aux_pins = pins_q;
  assign multiframe_bit_rx = multiframe_bit_pin_rx_q;
  assign channel_number = chan_q;
  assign irq = irq_q;

endmodule : app_aux_pin_port

// *** dv/app_aux_pin_port_checker.sv ***
// Checker for pin drive, pull-ups, straps and interrupt mask of the aux pin port
`timescale 1ns/1ns
module app_aux_chk
  import app_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic operating_mode_strap_a,
  input wire logic operating_mode_strap_b,
  input wire logic [7:0] aux_in,
  input wire app_pkg::app_pins_t aux_pins,
  input wire logic [2:0] channel_number,
  input wire logic irq
);
  logic wr_q;
  logic wrote_q;
  logic [7:0] adr_q;
  logic [7:0] dir_q;
  logic [7:0] tx_q;
  logic [7:0] drv_q;
  logic lt_w;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // LT-T and LT-S strap modes
  assign lt_w = operating_mode_strap_a ^ operating_mode_strap_b;
  // Shadow of host writes, so pin checks need no view of the bodies
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {wr_q, wrote_q, adr_q} <= '0;
      {dir_q, tx_q, drv_q} <= {APP_DIR_RST, APP_TX_RST, APP_DRV_RST};
    end
    else
    begin
      wr_q <= hsel & htrans[1] & hwrite & hready;
      adr_q <= haddr[7:0];
      wrote_q <= wrote_q | wr_q;
      if (wr_q && adr_q == APP_OFF_DIR) dir_q <= hwdata[7:0];
      if (wr_q && adr_q == APP_OFF_TX) tx_q <= hwdata[7:0];
      if (wr_q && adr_q == APP_OFF_DRV) drv_q <= hwdata[7:0];
    end
  end
  all_inputs_a: assert property (!wrote_q |-> aux_pins.oe == 8'h00)
    else $error("pin driven before any host write");
  irq_masked_a: assert property (!wrote_q |-> !irq)
    else $error("interrupt before mask written");
  strap_input_a: assert property (lt_w [*8] |-> aux_pins.oe[2:0] == 3'h0)
    else $error("channel strap pin driven");
  chan_decode_a: assert property ((lt_w && $stable(aux_in[2:0])) [*8] |-> channel_number == aux_in[2:0])
    else $error("channel number not strap value");
  chan_zero_a: assert property ((!lt_w && $stable(operating_mode_strap_a)) [*8] |-> channel_number == 3'h0)
    else $error("channel number outside linecard mode");
  gpio_drive_a: assert property ($stable({dir_q[3], tx_q[3], drv_q[3]}) [*2]
    |-> aux_pins.oe[3] == (!dir_q[3] && (drv_q[3] || !tx_q[3]))) else $error("pin 3 enable wrong");
  gpio_level_a: assert property (($stable(tx_q[3]) [*2] ##0 aux_pins.oe[3]) |-> aux_pins.out[3] == tx_q[3])
    else $error("pin 3 level wrong");
  pullup_ctl_a: assert property ($stable({dir_q[6], drv_q[6]}) [*2]
    |-> aux_pins.pullup_en[6] == !(!dir_q[6] && drv_q[6])) else $error("pin 6 pull-up wrong");
  pullup_none_a: assert property (aux_pins.pullup_en[5:0] == 6'h00)
    else $error("pull-up on pin without one");
  cover property (wr_q && adr_q == APP_OFF_TX);
  cover property ($rose(irq));
  cover property (lt_w && channel_number == 3'h7);
endmodule : app_aux_chk

bind app_aux_pin_port app_aux_chk u_app_aux_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .operating_mode_strap_a, .operating_mode_strap_b, .aux_in, .aux_pins, .channel_number, .irq);

// *** dv/app_board_model.sv ***
// Board model: resolves each aux line from port drive, board drivers and pull-ups
`timescale 1ns/1ns
module app_board_model
  import app_pkg::*;
(
  input wire logic clk,
  input wire app_pkg::app_pins_t pins,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] level
);
  logic [7:0] float_q = 8'h5A;
  // Floating lines wander, so a stale level never passes for a driven one
  always_ff @(posedge clk)
    float_q <= ~float_q;
  // Low wins on contention; undriven lines read high where pulled up, else wander
  assign level = (pins.oe & ext_en & pins.out & ext_val)
    | (pins.oe & ~ext_en & pins.out) | (~pins.oe & ext_en & ext_val)
    | (~pins.oe & ~ext_en & (pins.pullup_en | float_q));
endmodule : app_board_model

// *** dv/tb_top.sv ***
// Self-checking bench for the aux pin port
`timescale 1ns/1ns
module tb_top;
  import app_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic sa = 1'b0;
  logic sb = 1'b0;
  logic dclk = 1'b0;
  logic fsync = 1'b0;
  logic stop_go_output = 1'b0;
  logic mb_tx = 1'b0;
  logic [7:0] ext_val = 8'hFF;
  logic [7:0] ext_en = 8'hFF;
  logic hreadyout, hresp, mb_rx, irq, last, rsp;
  logic [31:0] hrdata, rd;
  logic [2:0] chan;
  logic [7:0] lvl, dir, tx, drv, ev, eo, en;
  app_pins_t pins;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  always #5 hclk = ~hclk;
  // Data clock at one eighth of the bus clock rate, edges on falling bus clock edges
  always #40 dclk = ~dclk;
  app_aux_pin_port u_app_aux_pin_port (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .aux_in(lvl), .operating_mode_strap_a(sa),
    .operating_mode_strap_b(sb), .data_clock(dclk), .frame_sync(fsync), .stop_go_bit(stop_go_output),
    .multiframe_bit_tx(mb_tx), .aux_pins(pins), .multiframe_bit_rx(mb_rx), .channel_number(chan), .irq);
  app_board_model u_app_board_model (.clk(hclk), .pins, .ext_en, .ext_val, .level(lvl));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Single word transfer; waits on ready in both phases, no latency assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk);
    while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk);
    while (hreadyout !== 1'b1);
    rd = hrdata;
    rsp = hresp;
  endtask : bus
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
    chk("resp", 32'h0, {31'h0, rsp});
  endtask : rdc
  // Enable only on outputs; open drain enables just while pulling low
  function automatic logic [7:0] exp_oe(input logic [7:0] d, input logic [7:0] t, input logic [7:0] v);
    return ~d & (v | ~t);
  endfunction : exp_oe
  // Low wins on a driven line; a line nobody drives reads high from its pull-up
  function automatic logic [7:0] exp_rx(input logic [7:0] d, input logic [7:0] t, input logic [7:0] e);
    return e & (d | t);
  endfunction : exp_rx
  // Hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      end_sim();
    end
  end
  initial
  begin
    rd = $urandom(30328);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("dir", APP_OFF_DIR, {24'h0, APP_DIR_RST});
    rdc("tx", APP_OFF_TX, 32'h0);
    rdc("drive", APP_OFF_DRV, 32'h0);
    rdc("func", APP_OFF_FUNC, 32'h0);
    rdc("mask", APP_OFF_IRQ_MASK, 32'h3);
    rdc("unmapped", 8'h40, 32'h0);
    chk("oe_rst", 32'h0, {24'h0, pins.oe});
    // Random direction, drive type, data and board levels
    repeat (12)
    begin
      dir = $urandom;
      tx = $urandom;
      drv = $urandom;
      ev = $urandom;
      en = {2'($urandom), 6'h3F};
      ext_val <= ev;
      ext_en <= en;
      bus(1'b1, APP_OFF_DIR, {24'h0, dir});
      bus(1'b1, APP_OFF_TX, {24'h0, tx});
      bus(1'b1, APP_OFF_DRV, {24'h0, drv});
      repeat (3) @(posedge hclk);
      eo = exp_oe(dir, tx, drv);
      chk("oe", {24'h0, eo}, {24'h0, pins.oe});
      chk("out", {24'h0, eo & drv & tx}, {24'h0, pins.out & pins.oe});
      chk("pullup", {30'h0, ~(~dir[7:6] & drv[7:6])}, {30'h0, pins.pullup_en[7:6]});
      rdc("rx", APP_OFF_RX, {24'h0, exp_rx(dir, tx, ev | ~en)});
    end
    ext_en <= 8'hFF;
    // Every strap mode; all eight channels since the data clock is the fast one
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 8; c++)
      begin
        sa <= m[0];
        sb <= m[1];
        ext_val <= {5'h1F, c[2:0]};
        repeat (8) @(posedge hclk);
        rdc("status", APP_OFF_STATUS, {26'h0, (m == 1 || m == 2) ? c[2:0] : 3'h0, m[2:0]});
        chk("chan", {29'h0, (m == 1 || m == 2) ? c[2:0] : 3'h0}, {29'h0, chan});
        chk("strap_oe", {29'h0, (m != 0) ? 3'h0 : eo[2:0]}, {29'h0, pins.oe[2:0]});
      end
    // Multiframe pin ignores its I/O setup: input in intelligent NT, output in TE
    bus(1'b1, APP_OFF_DIR, 32'h0);
    bus(1'b1, APP_OFF_FUNC, 32'h60);
    ext_val <= 8'hFF;
    repeat (6) @(posedge hclk);
    chk("multiframe_bit_pin_in", 32'h1, {30'h0, pins.oe[4], mb_rx});
    // Intelligent NT hands pins 0-2 back to general I/O
    rdc("int_nt", APP_OFF_STATUS, 32'h4);
    eo = exp_oe(8'h00, tx, drv);
    chk("int_nt_oe", {29'h0, eo[2:0]}, {29'h0, pins.oe[2:0]});
    sb <= 1'b0;
    sa <= 1'b0;
    mb_tx <= 1'b1;
    repeat (8) @(posedge hclk);
    chk("multiframe_bit_pin_out", 32'h3, {30'h0, pins.oe[4], pins.out[4]});
    // Frame sync on pin 5 and stop/go on pin 7, both levels
    bus(1'b1, APP_OFF_FUNC, 32'h11);
    fsync <= 1'b1;
    stop_go_output <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("alt_hi", 32'hF, {28'h0, pins.oe[5], pins.out[5], pins.oe[7], pins.out[7]});
    fsync <= 1'b0;
    stop_go_output <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("alt_lo", 32'hA, {28'h0, pins.oe[5], pins.out[5], pins.oe[7], pins.out[7]});
    // Bit clock: one output change per data clock period
    bus(1'b1, APP_OFF_FUNC, 32'h3);
    repeat (8) @(posedge hclk);
    n = 0;
    repeat (160)
    begin
      last = pins.out[5];
      @(posedge hclk);
      n += int'(pins.out[5] !== last);
    end
    chk("bclk_edges", 32'h1, {31'h0, n > 17 && n < 23});
    // Pin 6 falling edge, masked then unmasked; pin 7 low level
    bus(1'b1, APP_OFF_FUNC, 32'h8);
    bus(1'b1, APP_OFF_DIR, 32'hFF);
    repeat (6) @(posedge hclk);
    bus(1'b1, APP_OFF_IRQ_STAT, 32'h3);
    ext_val <= 8'hBF;
    repeat (6) @(posedge hclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdc("stat_edge", APP_OFF_IRQ_STAT, 32'h1);
    bus(1'b1, APP_OFF_IRQ_MASK, 32'h2);
    repeat (3) @(posedge hclk);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, APP_OFF_IRQ_STAT, 32'h1);
    ext_val <= 8'h3F;
    repeat (6) @(posedge hclk);
    rdc("stat_level", APP_OFF_IRQ_STAT, 32'h2);
    chk("irq_off", 32'h0, {31'h0, irq});
    bus(1'b1, APP_OFF_IRQ_STAT, 32'h2);
    rdc("stat_reset", APP_OFF_IRQ_STAT, 32'h2);
    end_sim();
  end
endmodule : tb_top
